// ---- src/rmsc_top.v ----
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RQ1 - Code 11 starts interrupt-driven generation
// RQ2 - Code 20 halts generation at once
// RQ3 - Completion reported only after generation finishes
// RQ4 - Wait limit in ms, zero waits forever
// RQ5 - Expired wait limit reports error, not completion
// RQ6 - Two memory channels, 0 and 1
// RQ7 - Only output channel 0 leaves memory 1 unused
// RQ8 - Host interleaves shared channels, scales start, length
// RQ9 - Write start counts samples, zero is first
// RQ10 - Write length counts samples from start
// RQ11 - Host fills whole memory before starting
// RQ12 - Memory words are always 16 bits
// RQ13 - Byte format: sample N low, N+1 high
// RQ14 - Word format: one sample, bit 15 top
// RQ15 - Halt ignores remaining post-trigger count
// RQ16 - State word reads 0, 10 or 20
// RQ17 - Other command codes are ignored
`include "rmsc_defs.vh"
module rmsc_top #(
    parameter [31:0] CYC_PER_MS = `RMSC_CYC_PER_MS,
    parameter AW = 6
) (
    input wire SYS_CLK,
    input wire RESET,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    output wire IRQ,
    input wire SAMPLE_CLK_IN,
    input wire TRIG_IN,
    output wire [15:0] OUT_CH0,
    output wire [15:0] OUT_CH1,
    output wire OUT_VALID
);
    localparam [1:0] ST_STOP = 2'h0;
    localparam [1:0] ST_ARMED = 2'h1;
    localparam [1:0] ST_TRIG = 2'h2;

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    reg wr_ph_reg;
    reg rd_ph_reg;
    reg rd_wait_reg;
    reg [29:0] idx_reg;
    reg [31:0] hrdata_reg;
    reg [31:0] rd_mux;
    wire take = HSEL & HTRANS[1] & HREADY;

    // Reads take one wait state so a write just before is seen
    assign HREADYOUT = ~(rd_ph_reg & ~rd_wait_reg);
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_reg;

    function wr_hit;
        input ph;
        input [29:0] cur;
        input [29:0] want;
        begin
            wr_hit = ph && (cur == want);
        end
    endfunction

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            wr_ph_reg <= 1'b0;
            rd_ph_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            idx_reg <= 30'h00000000;
            hrdata_reg <= `RMSC_ZERO32;
        end else begin
            if (HREADY) begin
                wr_ph_reg <= take & HWRITE;
                rd_ph_reg <= take & ~HWRITE;
            end
            if (take)
                idx_reg <= HADDR[31:2];
            rd_wait_reg <= rd_ph_reg & ~rd_wait_reg;
            if (rd_ph_reg & ~rd_wait_reg)
                hrdata_reg <= rd_mux;
        end
    end

    wire cmd_wr = wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_CMD);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg sclk_meta_reg;
    reg sclk_sync_reg;
    reg sclk_last_reg;
    reg trig_meta_reg;
    reg trig_sync_reg;
    reg trig_last_reg;
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_last_reg <= 1'b0;
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
            trig_last_reg <= 1'b0;
        end else begin
            sclk_meta_reg <= SAMPLE_CLK_IN;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_last_reg <= sclk_sync_reg;
            trig_meta_reg <= TRIG_IN;
            trig_sync_reg <= trig_meta_reg;
            trig_last_reg <= trig_sync_reg;
        end
    end
    wire tick = sclk_sync_reg & ~sclk_last_reg;
    wire trig_rise = trig_sync_reg & ~trig_last_reg;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    reg [31:0] cmd_reg;
    reg [`RMSC_CFG_W-1:0] cfg_reg;
    reg [31:0] rlen_reg;
    reg [31:0] wptr_reg;
    reg [31:0] wleft_reg;
    reg [31:0] wait_reg;
    reg [`RMSC_IRQ_W-1:0] mask_reg;
    reg [`RMSC_IRQ_W-1:0] istat_reg;
    reg [`RMSC_IRQ_W-1:0] ev;
    reg [1:0] st_reg;
    reg [1:0] st_next;
    wire ch1_on = cfg_reg[`RMSC_CFG_CH1];
    wire [1:0] dat_wr;
    wire more = (wleft_reg != `RMSC_ZERO32);

    assign dat_wr[0] = wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_DAT0) & more;
    // RQ7 memory 1 idle
    assign dat_wr[1] = wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_DAT1) & more & ch1_on;

    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            cmd_reg <= `RMSC_ZERO32;
            cfg_reg <= `RMSC_CFG_RST;
            rlen_reg <= `RMSC_ZERO32;
            wait_reg <= `RMSC_ZERO32;
            mask_reg <= {`RMSC_IRQ_W{1'b0}};
        end else begin
            if (cmd_wr)
                cmd_reg <= HWDATA;
            if (wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_CFG))
                cfg_reg <= HWDATA[`RMSC_CFG_W-1:0];
            if (wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_RLEN))
                rlen_reg <= HWDATA;
            // RQ4 wait limit held
            if (wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_WAIT))
                wait_reg <= HWDATA;
            if (wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_IMASK))
                mask_reg <= HWDATA[`RMSC_IRQ_W-1:0];
        end
    end

    // RQ9 start in samples
    // RQ10 length in samples
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            wptr_reg <= `RMSC_ZERO32;
            wleft_reg <= `RMSC_ZERO32;
        end else begin
            if (wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_WSTART))
                wptr_reg <= HWDATA;
            else if (|dat_wr)
                wptr_reg <= wptr_reg + `RMSC_ONE32;
            if (wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_WLEN))
                wleft_reg <= HWDATA;
            else if (|dat_wr)
                wleft_reg <= wleft_reg - `RMSC_ONE32;
        end
    end

    // Set wins over the write-one clear
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET)
            istat_reg <= {`RMSC_IRQ_W{1'b0}};
        else if (wr_hit(wr_ph_reg, idx_reg, `RMSC_IDX_ISTAT))
            istat_reg <= (istat_reg & ~HWDATA[`RMSC_IRQ_W-1:0]) | ev;
        else
            istat_reg <= istat_reg | ev;
    end
    assign IRQ = |(istat_reg & mask_reg);

    // ----------------------------------------
    // Replay memory channels
    // ----------------------------------------
    reg [31:0] play_reg;
    wire [31:0] mem_rd;
    genvar g;
    // RQ6 two memory channels
    // RQ12 16-bit words
    generate
        for (g = 0; g < 2; g = g + 1) begin : mc
            rmsc_mem_chan #(
                .AW(AW)
            ) u_mem (
                .clk(SYS_CLK),
                .rst(RESET),
                .wr_en(dat_wr[g]),
                .wr_idx(wptr_reg[AW:0]),
                .wr_byte(cfg_reg[`RMSC_CFG_FMT0+g]),
                .wr_data(HWDATA[15:0]),
                .rd_idx(play_reg[AW:0]),
                .rd_byte(cfg_reg[`RMSC_CFG_FMT0+g]),
                .rd_data_reg(mem_rd[g*16+:16])
            );
        end
    endgenerate

    // ----------------------------------------
    // Wait-limit timer
    // ----------------------------------------
    wire expired;
    rmsc_ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .clk(SYS_CLK),
        .rst(RESET),
        .run(st_reg != ST_STOP),
        .limit_ms(wait_reg),
        .expired_reg(expired)
    );

    // ----------------------------------------
    // Generation control
    // ----------------------------------------
    wire last = (play_reg + `RMSC_ONE32) >= rlen_reg;
    always @* begin
        st_next = st_reg;
        ev = {`RMSC_IRQ_W{1'b0}};
        // RQ2 halt from any state
        // RQ15 no post-trigger wait
        if (cmd_wr && HWDATA == `RMSC_CODE_HALT) begin
            st_next = ST_STOP;
            ev[`RMSC_IRQ_HALT] = (st_reg != ST_STOP);
        // RQ1 interrupt-driven start
        end else if (cmd_wr && HWDATA == `RMSC_CODE_LAUNCH) begin
            if (st_reg == ST_STOP)
                st_next = ST_ARMED;
        // RQ17 other codes ignored
        end else begin
            case (st_reg)
                ST_ARMED: begin
                    // RQ5 timeout is an error
                    if (expired) begin
                        st_next = ST_STOP;
                        ev[`RMSC_IRQ_TMO] = 1'b1;
                    end else if (trig_rise) begin
                        st_next = ST_TRIG;
                    end
                end
                ST_TRIG: begin
                    if (expired) begin
                        st_next = ST_STOP;
                        ev[`RMSC_IRQ_TMO] = 1'b1;
                    // RQ3 done after last sample
                    end else if (tick && last) begin
                        st_next = ST_STOP;
                        ev[`RMSC_IRQ_DONE] = 1'b1;
                    end
                end
                default: begin
                    st_next = st_reg;
                end
            endcase
        end
    end

    reg [15:0] out0_reg;
    reg [15:0] out1_reg;
    reg valid_reg;
    always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            st_reg <= ST_STOP;
            play_reg <= `RMSC_ZERO32;
            out0_reg <= 16'h0000;
            out1_reg <= 16'h0000;
            valid_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            valid_reg <= 1'b0;
            if (st_reg == ST_STOP)
                play_reg <= `RMSC_ZERO32;
            else if (st_reg == ST_TRIG && tick && st_next == ST_TRIG)
                play_reg <= play_reg + `RMSC_ONE32;
            if (st_reg == ST_TRIG && tick && !expired) begin
                out0_reg <= cfg_reg[`RMSC_CFG_CH0] ? mem_rd[15:0] : 16'h0000;
                out1_reg <= ch1_on ? mem_rd[31:16] : 16'h0000;
                valid_reg <= 1'b1;
            end
        end
    end
    assign OUT_CH0 = out0_reg;
    assign OUT_CH1 = out1_reg;
    assign OUT_VALID = valid_reg;

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    function [31:0] state_word;
        input [1:0] s;
        begin
            case (s)
                ST_ARMED: state_word = `RMSC_SW_ARMED;
                ST_TRIG: state_word = `RMSC_SW_TRIG;
                default: state_word = `RMSC_SW_STOP;
            endcase
        end
    endfunction

    always @* begin
        rd_mux = `RMSC_ZERO32;
        case (idx_reg)
            `RMSC_IDX_CMD: rd_mux = cmd_reg;
            // RQ16 state word codes
            `RMSC_IDX_STATE: rd_mux = state_word(st_reg);
            `RMSC_IDX_CFG: rd_mux[`RMSC_CFG_W-1:0] = cfg_reg;
            `RMSC_IDX_RLEN: rd_mux = rlen_reg;
            `RMSC_IDX_WSTART: rd_mux = wptr_reg;
            `RMSC_IDX_WLEN: rd_mux = wleft_reg;
            `RMSC_IDX_ISTAT: rd_mux[`RMSC_IRQ_W-1:0] = istat_reg;
            `RMSC_IDX_IMASK: rd_mux[`RMSC_IRQ_W-1:0] = mask_reg;
            `RMSC_IDX_WAIT: rd_mux = wait_reg;
            default: rd_mux = `RMSC_ZERO32;
        endcase
    end
endmodule
`default_nettype wire

// ---- src/rmsc_defs.vh ----
`ifndef RMSC_DEFS_VH
`define RMSC_DEFS_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define RMSC_IDX_CMD 30'h00000000
`define RMSC_IDX_STATE 30'h00000001
`define RMSC_IDX_CFG 30'h00000002
`define RMSC_IDX_RLEN 30'h00000003
`define RMSC_IDX_WSTART 30'h00000004
`define RMSC_IDX_WLEN 30'h00000005
`define RMSC_IDX_DAT0 30'h00000006
`define RMSC_IDX_DAT1 30'h00000007
`define RMSC_IDX_ISTAT 30'h00000008
`define RMSC_IDX_IMASK 30'h00000009
`define RMSC_IDX_WAIT 30'h000480da
// ----------------------------------------
// Command codes and state word values
// ----------------------------------------
`define RMSC_CODE_LAUNCH 32'h0000000b
`define RMSC_CODE_HALT 32'h00000014
`define RMSC_SW_ARMED 32'h00000000
`define RMSC_SW_TRIG 32'h0000000a
`define RMSC_SW_STOP 32'h00000014
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RMSC_CFG_CH0 0
`define RMSC_CFG_CH1 1
`define RMSC_CFG_FMT0 2
`define RMSC_CFG_W 4
`define RMSC_CFG_RST 4'h1
`define RMSC_IRQ_DONE 0
`define RMSC_IRQ_TMO 1
`define RMSC_IRQ_HALT 2
`define RMSC_IRQ_W 3
`define RMSC_ZERO32 32'h00000000
`define RMSC_ONE32 32'h00000001
// ----------------------------------------
// Timing
// ----------------------------------------
`define RMSC_MS_NS 32'h000f4240
`define RMSC_CLK_NS 32'h00000004
`define RMSC_CYC_PER_MS (`RMSC_MS_NS / `RMSC_CLK_NS)
`endif

// ---- src/rmsc_mem_chan.v ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// One 16-bit replay memory channel
// ----------------------------------------
module rmsc_mem_chan #(
    parameter AW = 6
) (
    input wire clk,
    input wire rst,
    input wire wr_en,
    input wire [AW:0] wr_idx,
    input wire wr_byte,
    input wire [15:0] wr_data,
    input wire [AW:0] rd_idx,
    input wire rd_byte,
    output reg [15:0] rd_data_reg
);
    reg [15:0] mem [0:(1<<AW)-1];
    // Byte format holds two samples per word
    function [AW-1:0] wsel;
        input [AW:0] i;
        input b;
        begin
            wsel = b ? i[AW:1] : i[AW-1:0];
        end
    endfunction
    wire [AW-1:0] ww = wsel(wr_idx, wr_byte);
    wire [AW-1:0] rw = wsel(rd_idx, rd_byte);
    // RQ13 odd sample in high byte
    always @(posedge clk) begin
        if (wr_en) begin
            if (!wr_byte)
                mem[ww] <= wr_data;
            else if (wr_idx[0])
                mem[ww][15:8] <= wr_data[7:0];
            else
                mem[ww][7:0] <= wr_data[7:0];
        end
    end
    // RQ14 word sample read whole
    always @(posedge clk or posedge rst) begin
        if (rst)
            rd_data_reg <= 16'h0000;
        else if (!rd_byte)
            rd_data_reg <= mem[rw];
        else if (rd_idx[0])
            rd_data_reg <= {8'h00, mem[rw][15:8]};
        else
            rd_data_reg <= {8'h00, mem[rw][7:0]};
    end
endmodule
`default_nettype wire

// ---- src/rmsc_ms_timer.v ----
`timescale 1ns/100ps
`default_nettype none
`include "rmsc_defs.vh"
// ----------------------------------------
// Millisecond wait-limit timer
// ----------------------------------------
module rmsc_ms_timer #(
    parameter [31:0] CYC_PER_MS = `RMSC_CYC_PER_MS
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [31:0] limit_ms,
    output reg expired_reg
);
    reg [31:0] cyc_reg;
    reg [31:0] ms_reg;
    wire ms_end = (cyc_reg == CYC_PER_MS - `RMSC_ONE32);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_reg <= `RMSC_ZERO32;
            ms_reg <= `RMSC_ZERO32;
            expired_reg <= 1'b0;
        end else if (!run) begin
            cyc_reg <= `RMSC_ZERO32;
            ms_reg <= `RMSC_ZERO32;
            expired_reg <= 1'b0;
        end else begin
            cyc_reg <= ms_end ? `RMSC_ZERO32 : cyc_reg + `RMSC_ONE32;
            if (ms_end)
                ms_reg <= ms_reg + `RMSC_ONE32;
            // RQ4 zero waits forever
            expired_reg <= (limit_ms != `RMSC_ZERO32) && (ms_reg >= limit_ms);
        end
    end
endmodule
`default_nettype wire

// ---- testbench/rmsc_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rmsc_defs.vh"
module rmsc_monitor (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic IRQ,
    input wire logic [15:0] OUT_CH0,
    input wire logic [15:0] OUT_CH1,
    input wire logic OUT_VALID
);
    // ----------
    // Data phase tracking
    // ----------
    wire taken = HSEL && HTRANS[1] && HREADY;
    logic wr_reg;
    logic rd_reg;
    logic [29:0] idx_reg;
    logic [3:0] cfg_reg;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            idx_reg <= 30'h0;
            cfg_reg <= 4'h1;
        end else if (HREADY) begin
            wr_reg <= taken && HWRITE;
            rd_reg <= taken && !HWRITE;
            idx_reg <= HADDR[31:2];
            if (wr_reg && idx_reg == `RMSC_IDX_CFG) begin
                cfg_reg <= HWDATA[3:0];
            end
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    a_resp_okay:
        assert property (HRESP == 1'b0) else $error("bad response");
    a_write_no_wait:
        assert property (taken && HWRITE |=> HREADYOUT) else $error("write wait");
    a_read_one_wait:
        assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait");
    a_strobe_single:
        assert property (OUT_VALID |=> !OUT_VALID) else $error("long strobe");
    a_halt_quiet:
        assert property (wr_reg && HREADY && idx_reg == `RMSC_IDX_CMD
            && HWDATA == `RMSC_CODE_HALT |=> ##1 !OUT_VALID [*8]) else $error("sample after halt");
    a_byte_top_zero:
        assert property (OUT_VALID && cfg_reg[2] |-> OUT_CH0[15:8] == 8'h00) else $error("byte top");
    a_idle_chan_one:
        assert property (OUT_VALID && !cfg_reg[1] |-> OUT_CH1 == 16'h0000) else $error("ch1 busy");
    a_irq_fall_write:
        assert property ($fell(IRQ) |-> $past(wr_reg)) else $error("irq dropped");
    a_state_codes:
        assert property (rd_reg && idx_reg == `RMSC_IDX_STATE && HREADYOUT
            |-> HRDATA inside {`RMSC_SW_ARMED, `RMSC_SW_TRIG, `RMSC_SW_STOP}) else $error("state");
endmodule
bind rmsc_top rmsc_monitor u_mon (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .OUT_CH0(OUT_CH0), .OUT_CH1(OUT_CH1),
    .OUT_VALID(OUT_VALID));
`default_nettype wire

// ---- testbench/rmsc_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rmsc_defs.vh"
module rmsc_host (
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata
);
    // ----------
    // Single word transfers
    // ----------
    initial {hsel, haddr, htrans, hwrite, hwdata} = '0;
    // Ready is sampled before the edge's own updates land
    task wr(input logic [29:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        @(posedge clk iff hready);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk iff hready);
    endtask
    task rd(input logic [29:0] idx, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        @(posedge clk iff hready);
        htrans <= 2'b00;
        @(posedge clk iff hready);
        d = hrdata;
    endtask
    function automatic logic [15:0] smp(input logic [15:0] base, input int k);
        return base + 16'(k) * 16'h0101;
    endfunction
    // one channel each, whole memory from zero
    task fill(input logic [29:0] dat, input int n, input logic [15:0] base);
        wr(`RMSC_IDX_WSTART, 32'h0);
        wr(`RMSC_IDX_WLEN, 32'(n));
        for (int k = 0; k < n; k++) begin
            wr(dat, {16'h0, smp(base, k)});
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "rmsc_defs.vh"
module testbench;
    localparam logic [29:0] CMD = `RMSC_IDX_CMD;
    localparam logic [29:0] STA = `RMSC_IDX_STATE;
    localparam logic [29:0] IST = `RMSC_IDX_ISTAT;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk = 1'b0;
    logic trig = 1'b0;
    logic hsel;
    logic hwrite;
    logic hready;
    logic hresp;
    logic irq;
    logic ovalid;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [15:0] out0;
    logic [15:0] out1;
    logic [15:0] q0[$];
    logic [15:0] q1[$];
    int bad_count = 0;
    int checks_done = 0;
    always #2 clk = ~clk;
    // ----------
    // Design and host
    // ----------
    rmsc_top #(.CYC_PER_MS(32'd4), .AW(6)) dut (.SYS_CLK(clk), .RESET(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq),
        .SAMPLE_CLK_IN(sclk), .TRIG_IN(trig), .OUT_CH0(out0), .OUT_CH1(out1), .OUT_VALID(ovalid));
    rmsc_host host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
    always @(posedge clk) begin
        if (ovalid === 1'b1) begin
            q0.push_back(out0);
            q1.push_back(out1);
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task rdchk(input logic [29:0] idx, input logic [31:0] want);
        logic [31:0] d;
        host.rd(idx, d);
        check(d, want);
    endtask
    // Half a cycle on, so the clearing edge has landed
    task irqchk(input logic want);
        @(negedge clk);
        check({31'h0, irq}, {31'h0, want});
        @(posedge clk);
    endtask
    task fire;
        trig <= 1'b1;
        repeat (4) @(posedge clk);
        trig <= 1'b0;
        rdchk(STA, `RMSC_SW_TRIG);
    endtask
    task ticks(input int n);
        repeat (n) begin
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            sclk <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask
    task expq(input logic [15:0] b0, input logic [15:0] b1, input int n, input logic [3:0] cfg);
        logic [15:0] e;
        check(32'(q0.size()), 32'(n));
        for (int k = 0; k < n; k++) begin
            e = host.smp(b0, k);
            e = cfg[2] ? {8'h00, e[7:0]} : e;
            check({16'h0, q0[k]}, {16'h0, e});
            e = cfg[1] ? host.smp(b1, k) : 16'h0000;
            check({16'h0, q1[k]}, {16'h0, e});
        end
        q0.delete();
        q1.delete();
    endtask
    task end_of_test;
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        end_of_test;
    end
    // ----------
    // Test sequence
    // ----------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(STA, `RMSC_SW_STOP);
        irqchk(1'b0);
        host.wr(30'h10, 32'hffffffff);
        rdchk(30'h10, 32'h0);
        host.wr(CMD, 32'h0000000a);
        rdchk(STA, `RMSC_SW_STOP);
        host.wr(`RMSC_IDX_WAIT, 32'h0);
        host.wr(`RMSC_IDX_RLEN, 32'h4);
        host.wr(`RMSC_IDX_CFG, 32'h3);
        host.wr(`RMSC_IDX_IMASK, 32'h1);
        host.fill(`RMSC_IDX_DAT0, 64, 16'h1200);
        host.fill(`RMSC_IDX_DAT1, 64, 16'hab00);
        host.wr(CMD, `RMSC_CODE_LAUNCH);
        rdchk(STA, `RMSC_SW_ARMED);
        host.wr(CMD, 32'h5);
        repeat (40) @(posedge clk);
        rdchk(STA, `RMSC_SW_ARMED);
        irqchk(1'b0);
        fire;
        ticks(4);
        expq(16'h1200, 16'hab00, 4, 4'h3);
        rdchk(STA, `RMSC_SW_STOP);
        rdchk(IST, 32'h1);
        irqchk(1'b1);
        host.wr(IST, 32'h1);
        irqchk(1'b0);
        host.wr(`RMSC_IDX_CFG, 32'h5);
        host.wr(`RMSC_IDX_RLEN, 32'h5);
        host.fill(`RMSC_IDX_DAT0, 128, 16'h0040);
        host.wr(CMD, `RMSC_CODE_LAUNCH);
        fire;
        ticks(5);
        expq(16'h0040, 16'h0000, 5, 4'h5);
        host.wr(`RMSC_IDX_CFG, 32'h1);
        host.wr(`RMSC_IDX_RLEN, 32'h14);
        host.wr(IST, 32'h7);
        host.wr(CMD, `RMSC_CODE_LAUNCH);
        fire;
        ticks(2);
        host.wr(CMD, `RMSC_CODE_HALT);
        rdchk(STA, `RMSC_SW_STOP);
        ticks(3);
        check(32'(q0.size()), 32'h2);
        check({16'h0, q0[1]}, 32'h00004342);
        rdchk(IST, 32'h4);
        q0.delete();
        q1.delete();
        host.wr(IST, 32'h7);
        host.wr(`RMSC_IDX_WAIT, 32'h2);
        host.wr(CMD, `RMSC_CODE_LAUNCH);
        rdchk(STA, `RMSC_SW_ARMED);
        repeat (20) @(posedge clk);
        rdchk(STA, `RMSC_SW_STOP);
        rdchk(IST, 32'h2);
        irqchk(1'b0);
        host.wr(`RMSC_IDX_IMASK, 32'h2);
        irqchk(1'b1);
        host.wr(IST, 32'h2);
        irqchk(1'b0);
        end_of_test;
    end
endmodule
`default_nettype wire
